// File: thermal_defines.svh
`ifndef THERMAL_DEFINES_SVH
`define THERMAL_DEFINES_SVH

// ****************************************
// Sizes
// ****************************************
`define ROW_COUNT        8
`define ROW_W            3
`define CNT_W            24
`define WEIGHT_W         4
`define THROTTLE_W       4

// ****************************************
// Reset values
// ****************************************
`define WEIGHT_HIT_RST   4'h1
`define WEIGHT_EMPTY_RST 4'h2
`define WEIGHT_MISS_RST  4'h3
`define THRESHOLD_RST    24'hFFFFFF
`define RD_THROTTLE_RST  4'h3
`define WR_THROTTLE_RST  4'h3

// ****************************************
// Timing
// ****************************************
`define WINDOW_NS        1000000
`define CLK_NS           8
`define WINDOW_CYCLES    (`WINDOW_NS / `CLK_NS)

`endif

// File: thermal_pkg.sv
package thermal_pkg;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    CYC_HIT   = 2'h0,
    CYC_EMPTY = 2'h1,
    CYC_MISS  = 2'h3
  } cycle_type_e;

  typedef struct packed {
    logic             valid;
    logic             is_write;
    logic [2:0]       row;
    cycle_type_e      kind;
    logic [3:0]       hexwords;
  } xfer_s;

  typedef struct packed {
    logic [3:0]  weight_hit;
    logic [3:0]  weight_empty;
    logic [3:0]  weight_miss;
    logic [23:0] threshold;
    logic [3:0]  rd_throttle;
    logic [3:0]  wr_throttle;
    logic        ot_irq_en;
    logic        ot_rd_throttle_en;
  } thermal_cfg_s;

  typedef enum logic [1:0] {
    ST_NORMAL   = 2'h0,
    ST_THROTTLE = 2'h1,
    ST_HOT      = 2'h3
  } throttle_state_e;

endpackage

// File: row_counter.sv
`timescale 1ns/100ps
`include "thermal_defines.svh"

module row_counter (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  resetn,
  input  wire logic                  ce,
  // Control
  input  wire logic                  clear,
  input  wire logic                  add,
  input  wire logic [`CNT_W-1:0]     amount,
  input  wire logic [`CNT_W-1:0]     threshold,
  // Status
  output logic                       over
);

  logic [`CNT_W-1:0] count;
  logic [`CNT_W-1:0] next_count;
  logic [`CNT_W:0]   sum;

  // ****************************************
  // Saturating accumulator
  // ****************************************
  always_comb begin
    sum        = {1'b0, count} + {1'b0, amount};
    next_count = count;
    if (clear) begin
      next_count = add ? amount : '0;
    end else if (add) begin
      next_count = sum[`CNT_W] ? '1 : sum[`CNT_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count <= '0;
    end else if (ce) begin
      count <= next_count;
    end
  end

  assign over = (count > threshold);

endmodule

// File: dram_thermal_throttle.sv
`timescale 1ns/100ps
`include "thermal_defines.svh"

// Function
// - Count hexwords per DRAM row
// - Weight counts by hit, miss, empty
// - Over threshold in window reduces accesses
// - Separate read and write throttle values
// - Low over-temp level: interrupt and/or read throttle
// - Wire-ORed input, throttle all DIMMs alike
// - Graphics sleep: display off, state kept
// - Runs in shared host clock domain
module dram_thermal_throttle (
  // Clock and reset
  input  wire logic                        CLK_IN,
  input  wire logic                        RESETN_IN,
  input  wire logic                        CE_IN,
  // Memory activity
  input  wire thermal_pkg::xfer_s          XFER_IN,
  // Configuration
  input  wire thermal_pkg::thermal_cfg_s   CFG_IN,
  // Sensor and power state
  input  wire logic                        OVER_TEMP_IN_N,
  input  wire logic                        GFX_SLEEP_POWERED_IN,
  // Throttle and status
  output logic                             RD_BLOCK_OUT,
  output logic                             WR_BLOCK_OUT,
  output logic                             THROTTLE_ACTIVE_OUT,
  output logic                             OVER_TEMP_IRQ_OUT,
  output logic                             DISPLAY_EN_OUT
);

  // ****************************************
  // Over-temp synchroniser
  // ****************************************
  logic ot_meta;
  logic ot_sync_n;

  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      ot_meta   <= 1'b1;
      ot_sync_n <= 1'b1;
    end else if (CE_IN) begin
      ot_meta   <= OVER_TEMP_IN_N;
      ot_sync_n <= ot_meta;
    end
  end

  logic hot;
  assign hot = !ot_sync_n;

  // ****************************************
  // Weighting and per-row counters
  // ****************************************
  logic [`WEIGHT_W-1:0]   weight;
  logic [2*`WEIGHT_W-1:0] product;
  logic [`CNT_W-1:0]    amount;
  logic [`ROW_COUNT-1:0] row_over;
  logic                 window_end;

  always_comb begin
    case (XFER_IN.kind)
      thermal_pkg::CYC_HIT:   weight = CFG_IN.weight_hit;
      thermal_pkg::CYC_EMPTY: weight = CFG_IN.weight_empty;
      thermal_pkg::CYC_MISS:  weight = CFG_IN.weight_miss;
      default:                weight = CFG_IN.weight_miss;
    endcase
    product = {{`WEIGHT_W{1'b0}}, weight} * {{`WEIGHT_W{1'b0}}, XFER_IN.hexwords};
    amount  = {{(`CNT_W-2*`WEIGHT_W){1'b0}}, product};
  end

  genvar r;
  generate
    for (r = 0; r < `ROW_COUNT; r = r + 1) begin : g_row
      row_counter u_cnt (
        .clk       (CLK_IN),
        .resetn    (RESETN_IN),
        .ce        (CE_IN),
        .clear     (window_end),
        .add       (XFER_IN.valid && (XFER_IN.row == `ROW_W'(r))),
        .amount    (amount),
        .threshold (CFG_IN.threshold),
        .over      (row_over[r])
      );
    end
  endgenerate

  // ****************************************
  // Throttle requests
  // ****************************************
  logic any_over;
  logic hot_rd;
  logic hot_irq;

  assign any_over = |row_over;
  assign hot_rd   = hot && CFG_IN.ot_rd_throttle_en;
  assign hot_irq  = hot && CFG_IN.ot_irq_en;

  // ****************************************
  // Monitoring window
  // ****************************************
  logic [31:0] win_cnt;
  logic [31:0] next_win_cnt;
  logic        over_seen;
  logic        next_over_seen;

  assign window_end = (win_cnt == 32'(`WINDOW_CYCLES - 1));

  always_comb begin
    next_win_cnt   = window_end ? 32'h0 : win_cnt + 32'h1;
    next_over_seen = window_end ? 1'b0 : (over_seen | any_over);
  end

  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      win_cnt   <= 32'h0;
      over_seen <= 1'b0;
    end else if (CE_IN) begin
      win_cnt   <= next_win_cnt;
      over_seen <= next_over_seen;
    end
  end

  // ****************************************
  // Throttle state machine
  // ****************************************
  thermal_pkg::throttle_state_e state;
  thermal_pkg::throttle_state_e next_state;
  logic                          over_now;

  assign over_now = over_seen | any_over;

  always_comb begin
    next_state = state;
    case (state)
      thermal_pkg::ST_NORMAL: begin
        if (hot_rd) begin
          next_state = thermal_pkg::ST_HOT;
        end else if (over_now) begin
          next_state = thermal_pkg::ST_THROTTLE;
        end
      end
      thermal_pkg::ST_THROTTLE: begin
        if (hot_rd) begin
          next_state = thermal_pkg::ST_HOT;
        end else if (window_end && !over_now) begin
          next_state = thermal_pkg::ST_NORMAL;
        end
      end
      thermal_pkg::ST_HOT: begin
        if (!hot_rd) begin
          next_state = thermal_pkg::ST_THROTTLE;
        end
      end
      default: next_state = thermal_pkg::ST_NORMAL;
    endcase
  end

  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      state <= thermal_pkg::ST_NORMAL;
    end else if (CE_IN) begin
      state <= next_state;
    end
  end

  // ****************************************
  // Duty-cycle throttle gates
  // ****************************************
  logic [`THROTTLE_W-1:0] phase;
  logic [`THROTTLE_W-1:0] next_phase;
  logic                   next_rd_block;
  logic                   next_wr_block;
  logic                   throttling;

  assign throttling = (state != thermal_pkg::ST_NORMAL);

  always_comb begin
    next_phase    = phase + `THROTTLE_W'(1);
    // Block the first N of every 16 slots; reads in ST_THROTTLE and ST_HOT, writes in ST_THROTTLE only
    next_rd_block = throttling && (phase < CFG_IN.rd_throttle);
    next_wr_block = (state == thermal_pkg::ST_THROTTLE) && (phase < CFG_IN.wr_throttle);
  end

  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      phase               <= '0;
      RD_BLOCK_OUT        <= 1'b0;
      WR_BLOCK_OUT        <= 1'b0;
    end else if (CE_IN) begin
      phase               <= next_phase;
      RD_BLOCK_OUT        <= next_rd_block;
      WR_BLOCK_OUT        <= next_wr_block;
    end
  end

  // ****************************************
  // Status outputs
  // ****************************************
  logic next_active;
  logic next_irq;
  logic next_display_en;

  always_comb begin
    next_active     = throttling;
    next_irq        = hot_irq;
    next_display_en = !GFX_SLEEP_POWERED_IN;
  end

  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      THROTTLE_ACTIVE_OUT <= 1'b0;
      OVER_TEMP_IRQ_OUT   <= 1'b0;
      DISPLAY_EN_OUT      <= 1'b0;
    end else if (CE_IN) begin
      THROTTLE_ACTIVE_OUT <= next_active;
      OVER_TEMP_IRQ_OUT   <= next_irq;
      DISPLAY_EN_OUT      <= next_display_en;
    end
  end

endmodule

// File: thermal_sensor_model.sv
`timescale 1ns/100ps
module thermal_sensor_model (
  // Sensor state
  input  wire logic hot_in,
  // Open-drain alert
  output wire       alert_out_n
);
  // ********
  // Output
  // ********
  assign alert_out_n = hot_in ? 1'b0 : 1'bz;
endmodule

// File: thermal_monitor.sv
`timescale 1ns/100ps
module thermal_monitor (
  // Inputs
  input wire logic                      CLK_IN,
  input wire logic                      RESETN_IN,
  input wire logic                      CE_IN,
  input wire thermal_pkg::xfer_s        XFER_IN,
  input wire thermal_pkg::thermal_cfg_s CFG_IN,
  input wire logic                      OVER_TEMP_IN_N,
  input wire logic                      GFX_SLEEP_POWERED_IN,
  // Outputs
  input wire logic                      RD_BLOCK_OUT,
  input wire logic                      WR_BLOCK_OUT,
  input wire logic                      THROTTLE_ACTIVE_OUT,
  input wire logic                      OVER_TEMP_IRQ_OUT,
  input wire logic                      DISPLAY_EN_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RESETN_IN);
  // ********
  // Properties
  // ********
  property p_irq_on;
    (!OVER_TEMP_IN_N && CFG_IN.ot_irq_en && CE_IN)[*3] |=> OVER_TEMP_IRQ_OUT;
  endproperty
  property p_irq_off;
    ((OVER_TEMP_IN_N || !CFG_IN.ot_irq_en) && CE_IN)[*3] |=> !OVER_TEMP_IRQ_OUT;
  endproperty
  property p_hot;
    (!OVER_TEMP_IN_N && CFG_IN.ot_rd_throttle_en && CE_IN)[*5] |=> THROTTLE_ACTIVE_OUT;
  endproperty
  property p_busy;
    XFER_IN.valid && CE_IN && XFER_IN.kind == thermal_pkg::CYC_MISS
      && CFG_IN.weight_miss * XFER_IN.hexwords > CFG_IN.threshold |-> ##[1:4] THROTTLE_ACTIVE_OUT;
  endproperty
  property p_disp;
    CE_IN |=> DISPLAY_EN_OUT == !$past(GFX_SLEEP_POWERED_IN);
  endproperty
  property p_rd_zero;
    (CFG_IN.rd_throttle == 4'h0)[*3] |-> !RD_BLOCK_OUT;
  endproperty
  property p_wr_zero;
    (CFG_IN.wr_throttle == 4'h0)[*3] |-> !WR_BLOCK_OUT;
  endproperty
  property p_freeze;
    !CE_IN |=> $stable({RD_BLOCK_OUT, WR_BLOCK_OUT, THROTTLE_ACTIVE_OUT, OVER_TEMP_IRQ_OUT, DISPLAY_EN_OUT});
  endproperty
  // ********
  // Checks
  // ********
  a_irq_on: assert property (p_irq_on) else $error("irq missing");
  a_irq_off: assert property (p_irq_off) else $error("irq stuck");
  a_hot: assert property (p_hot) else $error("no hot throttle");
  a_busy: assert property (p_busy) else $error("no busy throttle");
  a_disp: assert property (p_disp) else $error("display wrong");
  a_rd_zero: assert property (p_rd_zero) else $error("read blocked");
  a_wr_zero: assert property (p_wr_zero) else $error("write blocked");
  a_freeze: assert property (p_freeze) else $error("moved while frozen");
  c_irq: cover property (OVER_TEMP_IRQ_OUT);
  c_wr: cover property (THROTTLE_ACTIVE_OUT && WR_BLOCK_OUT);
  c_rd: cover property (RD_BLOCK_OUT);
endmodule

// File: test_dram_thermal_throttle.sv
`timescale 1ns/100ps
module test_dram_thermal_throttle;
  logic                      clk = 1'b0;
  logic                      resetn = 1'b0;
  logic                      ce = 1'b1;
  logic                      gfx = 1'b0;
  logic                      hot_a = 1'b0;
  logic                      hot_b = 1'b0;
  thermal_pkg::xfer_s        xfer = '0;
  thermal_pkg::thermal_cfg_s cfg = '{4'h1, 4'h2, 4'h3, 24'h000020, 4'h0, 4'h0, 1'b1, 1'b0};
  tri1                       ot_line_n;
  logic                      rd_blk, wr_blk, act, irq, disp;
  logic [7:0]                r, w;
  int                        error_cnt = 0;
  int                        n_checks = 0;
  int                        cycles = 0;
  always #4 clk = ~clk;
  thermal_sensor_model sens_a (.hot_in(hot_a), .alert_out_n(ot_line_n));
  thermal_sensor_model sens_b (.hot_in(hot_b), .alert_out_n(ot_line_n));
  dram_thermal_throttle dut_u (.CLK_IN(clk), .RESETN_IN(resetn), .CE_IN(ce), .XFER_IN(xfer), .CFG_IN(cfg),
    .OVER_TEMP_IN_N(ot_line_n), .GFX_SLEEP_POWERED_IN(gfx), .RD_BLOCK_OUT(rd_blk), .WR_BLOCK_OUT(wr_blk),
    .THROTTLE_ACTIVE_OUT(act), .OVER_TEMP_IRQ_OUT(irq), .DISPLAY_EN_OUT(disp));
  // ********
  // Helpers
  // ********
  task automatic close_out();
    if (error_cnt == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic send(input logic [2:0] row, input thermal_pkg::cycle_type_e kind, input logic [3:0] hw);
    @(posedge clk) xfer <= '{1'b1, row[0], row, kind, hw};
    @(posedge clk) xfer.valid <= 1'b0;
  endtask
  task automatic duty();
    r = 8'h00;
    w = 8'h00;
    repeat (16) begin
      tick(1);
      r = r + rd_blk;
      w = w + wr_blk;
    end
  endtask
  // ********
  // Scenarios
  // ********
  task automatic t_display();
    @(posedge clk) gfx <= 1'b1;
    tick(2);
    chk(disp, 8'h00);
    @(posedge clk) ce <= 1'b0;
    gfx <= 1'b0;
    tick(3);
    chk(disp, 8'h00);
    @(posedge clk) ce <= 1'b1;
    tick(2);
    chk(disp, 8'h01);
  endtask
  task automatic t_irq();
    @(posedge clk) hot_a <= 1'b1;
    tick(4);
    chk(irq, 8'h01);
    chk(act, 8'h00);
    @(posedge clk) hot_a <= 1'b0;
    tick(4);
    chk(irq, 8'h00);
    @(posedge clk) hot_b <= 1'b1;
    tick(4);
    chk(irq, 8'h01);
    @(posedge clk) hot_b <= 1'b0;
    tick(4);
    chk(irq, 8'h00);
  endtask
  task automatic t_rows();
    @(posedge clk) cfg.rd_throttle <= 4'h5;
    cfg.wr_throttle <= 4'h9;
    send(3'h0, thermal_pkg::CYC_HIT, 4'hF);
    send(3'h1, thermal_pkg::CYC_EMPTY, 4'h8);
    send(3'h1, thermal_pkg::CYC_HIT, 4'hF);
    tick(4);
    chk(act, 8'h00);
    send(3'h0, thermal_pkg::CYC_MISS, 4'hF);
    tick(4);
    chk(act, 8'h01);
    duty();
    chk(r, 8'h05);
    chk(w, 8'h09);
  endtask
  task automatic t_hot();
    @(posedge clk) cfg.ot_rd_throttle_en <= 1'b1;
    hot_a <= 1'b1;
    tick(6);
    chk(act, 8'h01);
    duty();
    chk(r, 8'h05);
    chk(w, 8'h00);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      close_out();
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    t_display();
    t_irq();
    t_rows();
    t_hot();
    close_out();
  end
endmodule
bind dram_thermal_throttle thermal_monitor mon_u (.CLK_IN(CLK_IN), .RESETN_IN(RESETN_IN), .CE_IN(CE_IN),
  .XFER_IN(XFER_IN), .CFG_IN(CFG_IN), .OVER_TEMP_IN_N(OVER_TEMP_IN_N), .GFX_SLEEP_POWERED_IN(GFX_SLEEP_POWERED_IN),
  .RD_BLOCK_OUT(RD_BLOCK_OUT), .WR_BLOCK_OUT(WR_BLOCK_OUT), .THROTTLE_ACTIVE_OUT(THROTTLE_ACTIVE_OUT),
  .OVER_TEMP_IRQ_OUT(OVER_TEMP_IRQ_OUT), .DISPLAY_EN_OUT(DISPLAY_EN_OUT));
